// [rtl/sil_top.sv]
// Safety interlock latch: redundant-pair monitors, latches, AXI4-Lite slave
// What this block does
// - Door input pair differing two seconds continuously raises a critical error.
// - Emergency stop pair differing two seconds continuously raises a critical error.
// - Door open holds the program and prohibits manipulator power.
// - Door-open and teaching-mode events are latched until released.
// - Release input open keeps latches; closed clears the door latch once the door is shut, and the teach latch once teach mode is off.
// - Clearing teach latch with door open keeps power prohibited.
// - Release closure acknowledges a change of teaching-mode state.
// - Unconnected safety inputs read as unsafe; no normal operation.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sil_disc_timer #(
    parameter int LIMIT = 250_000_000
) (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic in_a,
    input  wire logic in_b,
    output logic      expired
);
    logic [sil_pkg::DISC_W-1:0] count;
    wire differ = in_a ^ in_b;
    wire at_limit = (count >= sil_pkg::DISC_W'(LIMIT - 1));
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            count   <= '0;
            expired <= 1'b0;
        end else if (ce) begin
            if (!differ)
                count <= '0;
            else if (!at_limit)
                count <= count + 1'b1;
            expired <= differ && at_limit;
        end
    end

    a_count_restart: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !differ |=> count == '0)
        else $error("discrepancy timer not restarted on agreement");
endmodule

module sil_top #(
    parameter int DISC_CYCLES = sil_pkg::DISC_CYCLES
) (
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        ce,
    // Safety pins: high means closed (safe); open pins read low
    input  wire logic        door_a,
    input  wire logic        door_b,
    input  wire logic        estop_a,
    input  wire logic        estop_b,
    input  wire logic        release_in,
    input  wire logic        teach_mode,
    // Safety outputs
    output logic             prog_hold,
    output logic             power_prohibit,
    output logic             critical_err,
    output logic             irq,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready
);
    // Pin synchronisers, two stages each
    logic [5:0] sync1;
    logic [5:0] sync2;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (ce) begin
            sync1 <= {teach_mode, release_in, estop_b, estop_a, door_b, door_a};
            sync2 <= sync1;
        end
    end
    wire door_a_s  = sync2[0];
    wire door_b_s  = sync2[1];
    wire estop_a_s = sync2[2];
    wire estop_b_s = sync2[3];
    wire rel_s     = sync2[4];
    wire teach_s   = sync2[5];

    // Low (unconnected) counts as open / stopped
    wire door_open = !(door_a_s && door_b_s);
    wire estop_act = !(estop_a_s && estop_b_s);

    wire door_exp;
    wire estop_exp;
    sil_disc_timer #(.LIMIT(DISC_CYCLES)) u_door_timer (
        .clk_sys (clk_sys),
        .srst    (srst),
        .ce      (ce),
        .in_a    (door_a_s),
        .in_b    (door_b_s),
        .expired (door_exp)
    );
    sil_disc_timer #(.LIMIT(DISC_CYCLES)) u_estop_timer (
        .clk_sys (clk_sys),
        .srst    (srst),
        .ce      (ce),
        .in_a    (estop_a_s),
        .in_b    (estop_b_s),
        .expired (estop_exp)
    );

    // Latches and errors
    logic door_latch;
    logic teach_latch;
    logic door_err;
    logic estop_err;
    logic teach_prev;
    logic err_clear;
    // Teach latch set on entering teach mode; acknowledged by release closure
    wire teach_set  = teach_s && !teach_prev;
    wire next_door_latch  = door_open || (door_latch && !rel_s);
    wire next_teach_latch = teach_set || (teach_latch && !(rel_s && !teach_s));
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            door_latch  <= 1'b1;
            teach_latch <= 1'b0;
            teach_prev  <= 1'b0;
            door_err    <= 1'b0;
            estop_err   <= 1'b0;
        end else if (ce) begin
            door_latch  <= next_door_latch;
            teach_latch <= next_teach_latch;
            teach_prev  <= teach_s;
            // Set wins over software clear
            door_err    <= door_exp || (door_err && !err_clear);
            estop_err   <= estop_exp || (estop_err && !err_clear);
        end
    end

    wire any_err = door_err || estop_err || door_exp || estop_exp;
    wire next_prohibit = door_open || door_latch || teach_latch || estop_act || any_err;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prog_hold      <= 1'b1;
            power_prohibit <= 1'b1;
            critical_err   <= 1'b0;
        end else if (ce) begin
            prog_hold      <= door_open || door_latch || estop_act || any_err;
            power_prohibit <= next_prohibit;
            critical_err   <= any_err;
        end
    end

    // Interrupt status: sticky, write one to clear
    logic [sil_pkg::IRQ_W-1:0] irq_stat;
    logic [sil_pkg::IRQ_W-1:0] irq_mask;
    wire [sil_pkg::IRQ_W-1:0] irq_event = {teach_set, door_open && !door_latch,
                                           estop_exp, door_exp};

    // AXI4-Lite write path
    logic [7:0]  aw_addr;
    logic        aw_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_have;
    wire wr_go   = aw_have && w_have && !s_bvalid;
    wire wr_stat = wr_go && (aw_addr == sil_pkg::ADDR_IRQ) && w_strb[0];
    wire wr_mask = wr_go && (aw_addr == sil_pkg::ADDR_MASK) && w_strb[0];
    wire wr_ctrl = wr_go && (aw_addr == sil_pkg::ADDR_CTRL) && w_strb[0];
    wire wr_ok   = (aw_addr == sil_pkg::ADDR_IRQ) || (aw_addr == sil_pkg::ADDR_MASK)
                   || (aw_addr == sil_pkg::ADDR_CTRL);
    wire [sil_pkg::IRQ_W-1:0] clr_bits = wr_stat ? w_data[sil_pkg::IRQ_W-1:0] : '0;
    wire [sil_pkg::IRQ_W-1:0] next_irq_stat = irq_event | (irq_stat & ~clr_bits);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            aw_addr   <= '0;
            aw_have   <= 1'b0;
            w_data    <= '0;
            w_strb    <= '0;
            w_have    <= 1'b0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= sil_pkg::RESP_OKAY;
            irq_stat  <= '0;
            irq_mask  <= sil_pkg::MASK_RESET;
            err_clear <= 1'b0;
            irq       <= 1'b0;
        end else if (ce) begin
            s_awready <= !aw_have && !s_awready && s_awvalid;
            s_wready  <= !w_have && !s_wready && s_wvalid;
            if (s_awvalid && s_awready) begin
                aw_addr <= s_awaddr;
                aw_have <= 1'b1;
            end
            if (s_wvalid && s_wready) begin
                w_data <= s_wdata;
                w_strb <= s_wstrb;
                w_have <= 1'b1;
            end
            if (wr_go) begin
                aw_have  <= 1'b0;
                w_have   <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp  <= wr_ok ? sil_pkg::RESP_OKAY : sil_pkg::RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
            if (wr_mask)
                irq_mask <= w_data[sil_pkg::IRQ_W-1:0];
            err_clear <= wr_ctrl && w_data[sil_pkg::BIT_ERR_CLEAR];
            irq_stat  <= next_irq_stat;
            irq       <= |(next_irq_stat & irq_mask);
        end
    end

    // AXI4-Lite read path
    logic [31:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[sil_pkg::BIT_DOOR_OPEN]   = door_open;
        status_word[sil_pkg::BIT_DOOR_LATCH]  = door_latch;
        status_word[sil_pkg::BIT_TEACH_LATCH] = teach_latch;
        status_word[sil_pkg::BIT_DOOR_ERR]    = door_err;
        status_word[sil_pkg::BIT_ESTOP_ERR]   = estop_err;
        status_word[sil_pkg::BIT_ESTOP_ACT]   = estop_act;
        status_word[sil_pkg::BIT_HOLD]        = prog_hold;
        status_word[sil_pkg::BIT_PROHIBIT]    = power_prohibit;
        status_word[sil_pkg::BIT_RELEASE]     = rel_s;
    end
    wire rd_stat = (s_araddr == sil_pkg::ADDR_STATUS);
    wire rd_irq  = (s_araddr == sil_pkg::ADDR_IRQ);
    wire rd_mask = (s_araddr == sil_pkg::ADDR_MASK);
    wire rd_ctrl = (s_araddr == sil_pkg::ADDR_CTRL);
    wire [31:0] rd_word = rd_stat ? status_word :
                          rd_irq  ? {28'h0000000, irq_stat} :
                          rd_mask ? {28'h0000000, irq_mask} : 32'h0000_0000;
    wire rd_take = s_arvalid && s_arready;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= '0;
            s_rresp   <= sil_pkg::RESP_OKAY;
        end else if (ce) begin
            s_arready <= s_arvalid && !s_arready && !s_rvalid;
            if (rd_take) begin
                s_rvalid <= 1'b1;
                s_rdata  <= rd_word;
                s_rresp  <= (rd_stat || rd_irq || rd_mask || rd_ctrl) ?
                            sil_pkg::RESP_OKAY : sil_pkg::RESP_SLVERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // Checks
    a_door_prohibit: assert property (@(posedge clk_sys) disable iff (srst)
        ce && door_open |=> power_prohibit && prog_hold)
        else $error("door open did not prohibit power");
    a_door_latch_hold: assert property (@(posedge clk_sys) disable iff (srst)
        ce && door_latch && !rel_s |=> door_latch)
        else $error("door latch lost while release open");
    a_latch_release: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !door_open && rel_s |=> !door_latch)
        else $error("release closure did not clear door latch");
    a_teach_keep: assert property (@(posedge clk_sys) disable iff (srst)
        ce && $rose(teach_s) |=> teach_latch)
        else $error("teach entry not latched");
    a_teach_ack: assert property (@(posedge clk_sys) disable iff (srst)
        ce && teach_latch && !teach_set && rel_s && !teach_s |=> !teach_latch)
        else $error("release did not acknowledge teach change");
    a_teach_door_open: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !teach_latch && door_latch |=> power_prohibit)
        else $error("power allowed with door latched");
    a_unconnected: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !door_a_s && !door_b_s |=> power_prohibit)
        else $error("unconnected door allowed operation");
    a_door_err_set: assert property (@(posedge clk_sys) disable iff (srst)
        ce && door_exp |=> door_err && power_prohibit)
        else $error("door discrepancy error not raised");
    a_estop_err_set: assert property (@(posedge clk_sys) disable iff (srst)
        ce && estop_exp |=> estop_err)
        else $error("estop discrepancy error not raised");
    a_timer_restart: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !(estop_a_s ^ estop_b_s) |=> !estop_exp)
        else $error("estop timer not restarted on agreement");
    c_door_err: cover property (@(posedge clk_sys) disable iff (srst) $rose(door_err));
    c_release: cover property (@(posedge clk_sys) disable iff (srst) $fell(door_latch));
    c_teach_ack: cover property (@(posedge clk_sys) disable iff (srst) $fell(teach_latch));
    c_run: cover property (@(posedge clk_sys) disable iff (srst) $fell(power_prohibit));
endmodule
`default_nettype wire

// [rtl/sil_pkg.sv]
// Constants and register map of the safety interlock latch
package sil_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_STATUS  = 8'h00;
    localparam logic [7:0] ADDR_IRQ     = 8'h04;
    localparam logic [7:0] ADDR_MASK    = 8'h08;
    localparam logic [7:0] ADDR_CTRL    = 8'h0c;
    // Status field positions
    localparam int BIT_DOOR_OPEN   = 0;
    localparam int BIT_DOOR_LATCH  = 1;
    localparam int BIT_TEACH_LATCH = 2;
    localparam int BIT_DOOR_ERR    = 3;
    localparam int BIT_ESTOP_ERR   = 4;
    localparam int BIT_ESTOP_ACT   = 5;
    localparam int BIT_HOLD        = 6;
    localparam int BIT_PROHIBIT    = 7;
    localparam int BIT_RELEASE     = 8;
    // Irq field positions
    localparam int IRQ_DOOR_ERR    = 0;
    localparam int IRQ_ESTOP_ERR   = 1;
    localparam int IRQ_DOOR_LATCH  = 2;
    localparam int IRQ_TEACH_LATCH = 3;
    localparam int IRQ_W           = 4;
    // Ctrl field: clear both critical errors
    localparam int BIT_ERR_CLEAR   = 0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Discrepancy limit
    localparam longint DISC_LIMIT_NS = 64'd2_000_000_000;
    localparam longint CLK_PERIOD_NS = 64'd8;
    localparam int     DISC_CYCLES   = int'((DISC_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int     DISC_W        = 28;
endpackage

// [test/sil_switch_model.sv]
// Behavioural model of the door, stop, release and pendant switches
`timescale 1ns/1ps
`default_nettype none
module sil_switch_model (
    // Clock, reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // Commands from the bench
    input  wire logic plugged,
    input  wire logic door_cmd,
    input  wire logic door_skew,
    input  wire logic estop_cmd,
    input  wire logic estop_skew,
    input  wire logic release_cmd,
    input  wire logic teach_cmd,
    // Switch contacts, high means closed
    output logic      door_a,
    output logic      door_b,
    output logic      estop_a,
    output logic      estop_b,
    output logic      release_in,
    output logic      teach_mode
);
    logic [2:0] boot_cnt;
    logic       booted;
    assign booted = boot_cnt == 3'h7;
    // Door contacts held open until start-up has settled
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            boot_cnt <= 3'h0;
        end else if (!booted) begin
            boot_cnt <= boot_cnt + 3'h1;
        end
    end
    // Unplugged contacts read open, never a stale level
    always_ff @(posedge clk_sys) begin
        door_a     <= plugged & booted & door_cmd;
        door_b     <= plugged & booted & (door_cmd ^ door_skew);
        estop_a    <= plugged & estop_cmd;
        estop_b    <= plugged & (estop_cmd ^ estop_skew);
        release_in <= plugged & release_cmd;
        teach_mode <= plugged & teach_cmd;
    end
endmodule
`default_nettype wire

// [test/sil_top_tb.sv]
// Self-checking bench for the safety interlock latch
`timescale 1ns/1ps
`default_nettype none
module sil_top_tb;
    localparam int DISC = 16;
    logic        clk_sys = 1'h0;
    logic        srst = 1'h1;
    logic        ce = 1'h1;
    logic        plugged = 1'h1, door_cmd = 1'h1, door_skew = 1'h0;
    logic        estop_cmd = 1'h1, estop_skew = 1'h0, release_cmd = 1'h0, teach_cmd = 1'h0;
    logic        door_a, door_b, estop_a, estop_b, release_in, teach_mode;
    logic        prog_hold, power_prohibit, critical_err, irq;
    logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0, s_rdata, rd;
    logic [3:0]  s_wstrb = 4'hf;
    logic        s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
    logic        s_arvalid = 1'h0, s_rready = 1'h0;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0]  s_bresp, s_rresp, rsp;
    int          bad_count = 0, n_tests = 0;

    initial forever #4 clk_sys = ~clk_sys;

    sil_switch_model i_sil_switch_model (.clk_sys, .srst, .plugged, .door_cmd, .door_skew,
        .estop_cmd, .estop_skew, .release_cmd, .teach_cmd, .door_a, .door_b, .estop_a,
        .estop_b, .release_in, .teach_mode);
    sil_top #(.DISC_CYCLES(DISC)) i_sil_top (.clk_sys, .srst, .ce, .door_a, .door_b,
        .estop_a, .estop_b, .release_in, .teach_mode, .prog_hold, .power_prohibit,
        .critical_err, .irq, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chb(input string nm, input logic seen, input logic exp);
        chk(nm, {31'h0, seen}, {31'h0, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'h1;
        s_wvalid  <= 1'h1;
        s_bready  <= 1'h1;
        // Only the watchdog ends a stalled transfer
        do begin
            @(posedge clk_sys);
            if (s_awready === 1'h1) s_awvalid <= 1'h0;
            if (s_wready === 1'h1) s_wvalid <= 1'h0;
        end while (s_bvalid !== 1'h1);
        rsp = s_bresp;
        s_bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk_sys);
        s_araddr  <= a;
        s_arvalid <= 1'h1;
        s_rready  <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_arready === 1'h1) s_arvalid <= 1'h0;
        end while (s_rvalid !== 1'h1);
        rd  = s_rdata;
        rsp = s_rresp;
        s_rready <= 1'h0;
    endtask
    task automatic st(input string nm, input int b, input logic e);
        axi_rd(sil_pkg::ADDR_STATUS);
        chb(nm, rd[b], e);
    endtask
    task automatic skew(input int p, input logic v);
        if (p == 0) door_skew <= v;
        else estop_skew <= v;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Run takes about 375 cycles
    initial begin
        cyc(20000);
        bad_count++;
        wrap_up;
    end

    initial begin
        cyc(20);
        srst <= 1'h0;
        cyc(12);
        chb("prohibit_boot", power_prohibit, 1'h1);
        chb("hold_boot", prog_hold, 1'h1);
        axi_rd(sil_pkg::ADDR_MASK);
        chk("mask_reset", rd, 32'h0);
        axi_rd(sil_pkg::ADDR_CTRL);
        chk("ctrl_read", rd, 32'h0);
        axi_rd(8'h40);
        chk("unmapped_rd", {rd[29:0], rsp}, {30'h0, sil_pkg::RESP_SLVERR});
        axi_wr(8'h44, 32'hffffffff);
        chk("unmapped_wr", {30'h0, rsp}, {30'h0, sil_pkg::RESP_SLVERR});
        $display("test registers done");
        release_cmd <= 1'h1;
        cyc(8);
        chb("prohibit_rel", power_prohibit, 1'h0);
        chb("hold_rel", prog_hold, 1'h0);
        release_cmd <= 1'h0;
        cyc(8);
        door_cmd <= 1'h0;
        cyc(8);
        chb("hold_door", prog_hold, 1'h1);
        chb("prohibit_door", power_prohibit, 1'h1);
        door_cmd <= 1'h1;
        cyc(8);
        chb("prohibit_latched", power_prohibit, 1'h1);
        st("door_latch_kept", sil_pkg::BIT_DOOR_LATCH, 1'h1);
        release_cmd <= 1'h1;
        cyc(8);
        chb("prohibit_cleared", power_prohibit, 1'h0);
        release_cmd <= 1'h0;
        $display("test door done");
        teach_cmd <= 1'h1;
        cyc(8);
        st("teach_latch", sil_pkg::BIT_TEACH_LATCH, 1'h1);
        chb("prohibit_teach", power_prohibit, 1'h1);
        release_cmd <= 1'h1;
        cyc(8);
        st("teach_kept", sil_pkg::BIT_TEACH_LATCH, 1'h1);
        teach_cmd <= 1'h0;
        cyc(8);
        st("teach_cleared", sil_pkg::BIT_TEACH_LATCH, 1'h0);
        chb("prohibit_auto", power_prohibit, 1'h0);
        release_cmd <= 1'h0;
        teach_cmd <= 1'h1;
        cyc(8);
        teach_cmd <= 1'h0;
        door_cmd <= 1'h0;
        cyc(8);
        release_cmd <= 1'h1;
        cyc(8);
        st("teach_clr_open", sil_pkg::BIT_TEACH_LATCH, 1'h0);
        chb("prohibit_open", power_prohibit, 1'h1);
        door_cmd <= 1'h1;
        cyc(8);
        chb("prohibit_resume", power_prohibit, 1'h0);
        release_cmd <= 1'h0;
        $display("test teach done");
        chb("irq_masked", irq, 1'h0);
        axi_rd(sil_pkg::ADDR_IRQ);
        chk("irq_events", rd, (32'h1 << sil_pkg::IRQ_DOOR_LATCH)
            | (32'h1 << sil_pkg::IRQ_TEACH_LATCH));
        axi_wr(sil_pkg::ADDR_MASK, 32'h3);
        axi_rd(sil_pkg::ADDR_MASK);
        chk("mask_back", rd, 32'h00000003);
        axi_wr(sil_pkg::ADDR_IRQ, 32'hf);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 2; k++) begin
                skew(p, 1'h1);
                cyc(DISC - 6);
                skew(p, 1'h0);
                cyc(4);
            end
            chb("err_short", critical_err, 1'h0);
            skew(p, 1'h1);
            cyc(DISC + 8);
            chb("err_long", critical_err, 1'h1);
            chb("irq_err", irq, 1'h1);
            st("err_bit", (p == 0) ? sil_pkg::BIT_DOOR_ERR : sil_pkg::BIT_ESTOP_ERR,
               1'h1);
            skew(p, 1'h0);
            cyc(8);
            axi_wr(sil_pkg::ADDR_CTRL, 32'h1);
            axi_wr(sil_pkg::ADDR_IRQ, 32'h3);
            cyc(4);
            chb("err_cleared", critical_err, 1'h0);
            chb("irq_cleared", irq, 1'h0);
        end
        $display("test discrepancy done");
        release_cmd <= 1'h1;
        cyc(8);
        chb("prohibit_run", power_prohibit, 1'h0);
        release_cmd <= 1'h0;
        cyc(4);
        // Enable low: the opened door must not be seen until enable returns
        ce       <= 1'h0;
        door_cmd <= 1'h0;
        cyc(8);
        chb("prohibit_frozen", power_prohibit, 1'h0);
        chb("hold_frozen", prog_hold, 1'h0);
        ce <= 1'h1;
        cyc(8);
        chb("prohibit_thawed", power_prohibit, 1'h1);
        door_cmd <= 1'h1;
        $display("test enable done");
        plugged <= 1'h0;
        cyc(8);
        chb("hold_unplugged", prog_hold, 1'h1);
        chb("prohibit_unplugged", power_prohibit, 1'h1);
        $display("test unplugged done");
        wrap_up;
    end
endmodule
`default_nettype wire
